// >>> core/laser_cmd_if.sv
`timescale 1ns/100ps
interface laser_cmd_if;
  import laser_freq_monitor_pkg::*;
  logic        req;
  logic        write;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        rsp;
  status_t     status;
  cond_t       cond;
  logic [15:0] rdata;
  modport device (input req, write, addr, wdata, output rsp, status, cond, rdata);
  modport host   (output req, write, addr, wdata, input rsp, status, cond, rdata);
endinterface

// >>> core/laser_freq_host.sv
`timescale 1ns/100ps
`include "laser_freq_monitor_defs.svh"
module laser_freq_host
  import laser_freq_monitor_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // command link
  laser_cmd_if.host        cmd,
  // user request
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  output logic             busy,
  // user answer
  output logic             done,
  output logic             error,
  output cond_t            cond,
  output logic [15:0]      rdata
);
  typedef enum logic {idle, wait_rsp} host_state_t;
  host_state_t state_r;
  logic        req_r;
  logic        write_r;
  logic [7:0]  addr_r;
  logic [15:0] wdata_r;
  logic        done_r;
  logic        error_r;
  cond_t       cond_r;
  logic [15:0] rdata_r;

  // one command outstanding; start ignored while busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= idle;
      req_r   <= 1'b0;
      write_r <= 1'b0;
      addr_r  <= 8'h00;
      wdata_r <= 16'h0000;
    end else begin
      req_r <= 1'b0;
      unique case (state_r)
        idle: if (start) begin
          req_r   <= 1'b1;
          write_r <= write;
          addr_r  <= addr;
          wdata_r <= wdata;
          state_r <= wait_rsp;
        end
        wait_rsp: if (cmd.rsp) state_r <= idle;
      endcase
    end
  end

  // capture answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_r  <= 1'b0;
      error_r <= 1'b0;
      cond_r  <= cond_ok;
      rdata_r <= 16'h0000;
    end else begin
      done_r <= cmd.rsp;
      if (cmd.rsp) begin
        error_r <= (cmd.status == execution_error_status);
        cond_r  <= cmd.cond;
        rdata_r <= cmd.rdata;
      end
    end
  end

  assign cmd.req   = req_r;
  assign cmd.write = write_r;
  assign cmd.addr  = addr_r;
  assign cmd.wdata = wdata_r;
  assign busy      = (state_r != idle);
  assign done      = done_r;
  assign error     = error_r;
  assign cond      = cond_r;
  assign rdata     = rdata_r;
endmodule

// >>> core/laser_freq_monitor_defs.svh
// Contract
// - first-channel words writable only while output disabled
// - write while output enabled gives execution error
// - word write order carries no meaning
// - host sets both words before enabling output
// - words are whole THz and 0.1 GHz units
// - first-channel words have built-in default
// - read-only current frequency pair, THz and 0.1 GHz
// - current = (channel-1)*grid + first channel, in 0.1 GHz units
// - current frequency readable with output on or off
// - current frequency consistent with grid after reset; the code resets it to zero and recomputes it from the first clock after reset
// - OK with data, or error code with zero
// - read-only output power estimate register
// - power is signed hundredths of a dBm
// - read-only temperature, signed hundredths of degree
// - shown temperature is the fatal-check temperature
// - grid spacing is signed 0.1 GHz units
`ifndef LASER_FREQ_MONITOR_DEFS_SVH
`define LASER_FREQ_MONITOR_DEFS_SVH
`define REG_FCF_THZ        8'h35
`define REG_FCF_TENTH      8'h36
`define REG_CUR_THZ        8'h40
`define REG_CUR_TENTH      8'h41
`define REG_POWER          8'h42
`define REG_TEMP           8'h43
`define FCF_THZ_RESET      16'h00C2
`define FCF_TENTH_RESET    16'h06D6
`define TENTHS_PER_THZ     32'd10000
`define ERR_DATA           16'h0000
`endif

// >>> core/laser_freq_monitor_pkg.sv
package laser_freq_monitor_pkg;
  // answer status of a command
  typedef enum logic {status_ok, execution_error_status} status_t;
  // error condition field
  typedef enum logic [2:0] {
    cond_ok, command_busy_error, command_ignored_error,
    execution_failure_error, vendor_defined_error, read_only_write_error
  } cond_t;
endpackage

// >>> core/laser_freq_monitor_regs.sv
`timescale 1ns/100ps
`include "laser_freq_monitor_defs.svh"
module laser_freq_monitor_regs
  import laser_freq_monitor_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // command link
  laser_cmd_if.device      cmd,
  // module state
  input  wire logic        output_enabled,
  input  wire logic [15:0] channel,
  input  wire logic [15:0] grid_spacing,
  input  wire logic [15:0] power_estimate,
  input  wire logic [15:0] temperature,
  // configured first channel
  output logic      [15:0] fcf_thz,
  output logic      [15:0] fcf_tenth
);
  logic [15:0] fcf_thz_r;
  logic [15:0] fcf_tenth_r;
  logic [15:0] cur_thz_r;
  logic [15:0] cur_tenth_r;
  logic        rsp_r;
  status_t     status_r;
  cond_t       cond_r;
  logic [15:0] rdata_r;
  logic signed [31:0] total_nxt;
  logic [31:0] total_u;
  logic        hit_fcf;
  logic        hit_ro;
  logic        fcf_write_ok;

  // register number decode, used by the store only; the answer path decodes cmd.addr in its own case
  function automatic logic is_fcf_addr(input logic [7:0] a);
    return (a == `REG_FCF_THZ) || (a == `REG_FCF_TENTH);
  endfunction

  // computed registers; a write here must never reach any storage
  function automatic logic is_ro_addr(input logic [7:0] a);
    return (a == `REG_CUR_THZ) || (a == `REG_CUR_TENTH) || (a == `REG_POWER)
           || (a == `REG_TEMP);
  endfunction

  // whole THz part of a frequency held in 0.1 GHz units
  function automatic logic [15:0] thz_part(input logic [31:0] t);
    return 16'(t / `TENTHS_PER_THZ);
  endfunction

  // remainder below one THz, still in 0.1 GHz units
  function automatic logic [15:0] tenth_part(input logic [31:0] t);
    return 16'(t % `TENTHS_PER_THZ);
  endfunction

  // decoded request; the answer path repeats the output_enabled refuse decision on its own
  always_comb begin
    hit_fcf      = is_fcf_addr(cmd.addr);
    hit_ro       = is_ro_addr(cmd.addr);
    fcf_write_ok = cmd.req && cmd.write && hit_fcf && !output_enabled;
  end

  // frequency in 0.1 GHz units; grid is signed
  always_comb begin
    total_nxt = ($signed({16'h0000, channel}) - 32'sd1) * $signed({{16{grid_spacing[15]}},
                grid_spacing}) + $signed(32'(fcf_thz_r) * `TENTHS_PER_THZ)
                + $signed({16'h0000, fcf_tenth_r});
    total_u = 32'(total_nxt);
  end

  // recomputed every cycle; reset loads zero, inputs followed from the next clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_thz_r   <= 16'h0000;
      cur_tenth_r <= 16'h0000;
    end else begin
      cur_thz_r   <= thz_part(total_u);
      cur_tenth_r <= tenth_part(total_u);
    end
  end

  // first-channel words, independent so order does not matter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fcf_thz_r   <= `FCF_THZ_RESET;
      fcf_tenth_r <= `FCF_TENTH_RESET;
    end else if (fcf_write_ok) begin
      if (cmd.addr == `REG_FCF_THZ) fcf_thz_r <= cmd.wdata;
      if (cmd.addr == `REG_FCF_TENTH) fcf_tenth_r <= cmd.wdata;
    end
  end

  // one-cycle answer per request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_r    <= 1'b0;
      status_r <= status_ok;
      cond_r   <= cond_ok;
      rdata_r  <= 16'h0000;
    end else begin
      rsp_r <= cmd.req;
      if (cmd.req) begin
        status_r <= status_ok;
        cond_r   <= cond_ok;
        rdata_r  <= `ERR_DATA;
        unique case (cmd.addr)
          `REG_FCF_THZ, `REG_FCF_TENTH: begin
            if (cmd.write) begin
              if (output_enabled) begin
                status_r <= execution_error_status;
                cond_r   <= execution_failure_error;
              end else begin
                rdata_r <= cmd.wdata;
              end
            end else begin
              rdata_r <= (cmd.addr == `REG_FCF_THZ) ? fcf_thz_r : fcf_tenth_r;
            end
          end
          `REG_CUR_THZ, `REG_CUR_TENTH, `REG_POWER, `REG_TEMP: begin
            if (cmd.write) begin
              status_r <= execution_error_status;
              cond_r   <= read_only_write_error;
            end else begin
              unique case (cmd.addr)
                `REG_CUR_THZ:   rdata_r <= cur_thz_r;
                `REG_CUR_TENTH: rdata_r <= cur_tenth_r;
                `REG_POWER:     rdata_r <= power_estimate;
                default:        rdata_r <= temperature;
              endcase
            end
          end
          default: begin
            status_r <= execution_error_status;
            cond_r   <= command_ignored_error;
          end
        endcase
      end
    end
  end

  assign cmd.rsp    = rsp_r;
  assign cmd.status = status_r;
  assign cmd.cond   = cond_r;
  assign cmd.rdata  = rdata_r;
  assign fcf_thz    = fcf_thz_r;
  assign fcf_tenth  = fcf_tenth_r;
endmodule

// >>> verification/laser_cmd_sva.sv
`timescale 1ns/100ps
module laser_cmd_sva
  import laser_freq_monitor_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // command link
  input wire logic        req,
  input wire logic        write,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        rsp,
  input wire status_t     status,
  input wire cond_t       cond,
  input wire logic [15:0] rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // answers come exactly one cycle after a request, never pending
  a_rsp_next_cycle:
    assert property (req |=> rsp) else $error("answer missing");
  a_no_stray_rsp:
    assert property (!req |=> !rsp) else $error("answer without request");
  a_ro_write_refused:
    assert property (req && write && addr inside {[8'h40:8'h43]} |=>
      status == execution_error_status && cond == read_only_write_error) else $error("ro write");
  a_err_zero_data:
    assert property (rsp && status == execution_error_status |-> rdata == 16'h0000)
      else $error("error data not zero");
  a_write_echo:
    assert property (rsp && status == status_ok && $past(write) |-> rdata == $past(wdata))
      else $error("write not echoed");
  a_fcf_refuse_kind:
    assert property (req && write && addr inside {8'h35, 8'h36} |=>
      status == status_ok || cond == execution_failure_error) else $error("fcf error kind");
  a_cur_read_ok:
    assert property (req && !write && addr inside {[8'h40:8'h43]} |=> status == status_ok)
      else $error("read refused");
  a_answer_stands:
    assert property (!rsp |-> $stable(rdata) && $stable(cond) && $stable(status))
      else $error("answer moved");
endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
  import laser_freq_monitor_pkg::*;
  logic        clk, rst, start, write, oe, busy, done, error;
  logic [7:0]  addr, a;
  logic [15:0] wdata, chan, grid, pwr, temp, rdata, fthz, ften, th, tn;
  cond_t       cond;
  int          mismatches, n_checks, i, k;
  laser_cmd_if u_laser_cmd_if ();
  laser_freq_monitor_regs u_laser_freq_monitor_regs (.clk, .rst, .cmd(u_laser_cmd_if.device),
    .output_enabled(oe), .channel(chan), .grid_spacing(grid), .power_estimate(pwr),
    .temperature(temp), .fcf_thz(fthz), .fcf_tenth(ften));
  laser_freq_host u_laser_freq_host (.clk, .rst, .cmd(u_laser_cmd_if.host), .start, .write,
    .addr, .wdata, .busy, .done, .error, .cond, .rdata);
  laser_cmd_sva u_sva (.clk, .rst, .req(u_laser_cmd_if.req), .write(u_laser_cmd_if.write),
    .addr(u_laser_cmd_if.addr), .wdata(u_laser_cmd_if.wdata), .rsp(u_laser_cmd_if.rsp),
    .status(u_laser_cmd_if.status), .cond(u_laser_cmd_if.cond), .rdata(u_laser_cmd_if.rdata));
  // 100 ns clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // expected answers as {error, cond, data}
  function logic [19:0] ok(input logic [15:0] d);
    return {1'h0, cond_ok, d};
  endfunction
  function logic [19:0] err(input cond_t c);
    return {1'h1, c, 16'h0000};
  endfunction
  // current frequency in 0.1 GHz, split into THz and remainder
  function logic [15:0] cur(input logic hi);
    int t;
    t = (int'(chan) - 1) * int'($signed(grid)) + int'(th) * 10000 + int'(tn);
    return hi ? 16'(t / 10000) : 16'(t % 10000);
  endfunction
  // one command through the host; wait bounded, a hang ends the run
  task xfer(input logic w, input logic [7:0] ad, input logic [15:0] d, input logic [19:0] e);
    int n;
    @(posedge clk);
    start <= 1'h1;
    write <= w;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    start <= 1'h0;
    for (n = 0; n < 8 && done !== 1'h1; n++) begin
      @(posedge clk);
      #1;
      if (n == 0) chk("busy", busy, 1'h1);
    end
    if (n == 8) begin
      mismatches++;
      close_out;
    end else begin
      chk("answer", {error, cond, rdata}, e);
      chk("idle", busy, 1'h0);
    end
  endtask
  initial begin
    void'($urandom(26));
    {rst, start, write, oe, addr, wdata, pwr, temp} = '0;
    rst = 1'h1;
    chan = 16'h0001;
    grid = 16'h0064;
    th = 16'h00C2;
    tn = 16'h06D6;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    xfer(1'h0, 8'h35, 16'h0000, ok(th));
    xfer(1'h0, 8'h36, 16'h0000, ok(tn));
    xfer(1'h0, 8'h40, 16'h0000, ok(cur(1'h1)));
    for (i = 0; i < 8; i++) begin
      oe <= 1'h0;
      chan <= 16'($urandom_range(1, 96));
      grid <= 16'($urandom_range(0, 1000)) - 16'h01F4;
      pwr <= 16'($urandom);
      temp <= 16'($urandom);
      th = 16'($urandom_range(190, 196));
      tn = (i == 0) ? 16'h270F : 16'($urandom_range(0, 9999));
      // alternate which word goes first
      for (k = 0; k < 2; k++) begin
        a = 8'h35 + 8'((k + i) % 2);
        xfer(1'h1, a, (a == 8'h35) ? th : tn, ok((a == 8'h35) ? th : tn));
      end
      chk("fcf", {fthz, ften}, {th, tn});
      xfer(1'h0, 8'h40, 16'h0000, ok(cur(1'h1)));
      xfer(1'h0, 8'h41, 16'h0000, ok(cur(1'h0)));
      oe <= 1'h1;
      xfer(1'h0, 8'h41, 16'h0000, ok(cur(1'h0)));
      xfer(1'h1, 8'h35 + 8'(i % 2), 16'h0000, err(execution_failure_error));
      xfer(1'h0, 8'h35, 16'h0000, ok(th));
      xfer(1'h0, 8'h42, 16'h0000, ok(pwr));
      xfer(1'h0, 8'h43, 16'h0000, ok(temp));
      xfer(1'h1, 8'h40 + 8'(i % 4), 16'hFFFF, err(read_only_write_error));
      xfer(1'h0, 8'h37 + 8'(i), 16'h0000, err(command_ignored_error));
    end
    close_out;
  end
endmodule
